// ===== rtl/mflpc_params.svh
`ifndef MFLPC_PARAMS_SVH
`define MFLPC_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MFLPC_ADDR_W 11
`define MFLPC_OFS_RX_LIMIT 11'h414
`define MFLPC_OFS_TX_LIMIT 11'h418
`define MFLPC_OFS_TS_LATENCY 11'h420
`define MFLPC_OFS_PRIO_FIRST 11'h480
`define MFLPC_OFS_PRIO_LAST 11'h49C
`define MFLPC_OFS_LEGACY 11'h4A0
`define MFLPC_PRIO_COUNT 8

// ****************************************************************
// Field positions
// ****************************************************************
`define MFLPC_LIMIT_EN_BIT 16
`define MFLPC_LIMIT_SIZE_MSB 14
`define MFLPC_TS_CORR_BIT 16
`define MFLPC_TS_LAT_MSB 15
`define MFLPC_HALF_W 16

// ****************************************************************
// Reset values
// ****************************************************************
`define MFLPC_RST_LIMIT_SIZE 15'h05EE
`define MFLPC_RST_LIMIT_EN 1'h0
`define MFLPC_RST_TS_LAT_CF 16'h0080
`define MFLPC_RST_TS_LAT_OTHER 16'h0060
`define MFLPC_RST_TS_CORR 1'h1
`define MFLPC_RST_QUANTA 16'hFFFF
`define MFLPC_RST_REFRESH 16'hFF00

// ****************************************************************
// Timing
// ****************************************************************
`define MFLPC_READ_LATENCY 1

`endif

// ===== rtl/mflpc_pkg.sv
package mflpc_pkg;

    typedef struct packed {
        logic rxEnable;
        logic [14:0] rxSize;
        logic txEnable;
        logic [14:0] txSize;
    } mflpc_limits_s;

    typedef struct packed {
        logic correctEnable;
        logic [15:0] latencyNs;
    } mflpc_ts_s;

    typedef struct packed {
        logic [15:0] refresh;
        logic [15:0] quanta;
    } mflpc_pause_s;

    typedef mflpc_pause_s [7:0] mflpc_pause_arr_t;

endpackage : mflpc_pkg

// ===== rtl/mflpc_pause_slot.sv
`include "mflpc_params.svh"

module mflpc_pause_slot (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [31:0] wrData,
    output mflpc_pkg::mflpc_pause_s value
);

    // ****************************************************************
    // Storage with no reset: default holds only until first write
    // ****************************************************************
    mflpc_pkg::mflpc_pause_s value_reg = '{refresh: `MFLPC_RST_REFRESH, quanta: `MFLPC_RST_QUANTA};
    mflpc_pkg::mflpc_pause_s value_next;

    assign value_next = wrEn ? mflpc_pkg::mflpc_pause_s'(wrData) : value_reg;

    always_ff @(posedge clk) begin
        value_reg <= value_next;
    end

    assign value = value_reg;

    AST_PAUSE_WRITE: assert property (@(posedge clk) wrEn |=> value == $past(wrData))
        else $error("pause slot did not take written word");
    AST_PAUSE_HOLD: assert property (@(posedge clk) !wrEn |=> $stable(value))
        else $error("pause slot changed without a write");

endmodule : mflpc_pause_slot

// ===== rtl/mflpc_config.sv
`include "mflpc_params.svh"

module mflpc_config #(
    parameter bit TS_PRESENT = 1'b1,
    parameter bit TS_ONE_STEP_CF = 1'b1,
    parameter bit PFC_PRESENT = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [10:0] regAddr,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regRdValid,
    output mflpc_pkg::mflpc_limits_s limits,
    output mflpc_pkg::mflpc_ts_s tsCfg,
    output mflpc_pkg::mflpc_pause_arr_t pauseCfg,
    output logic [15:0] legacyRefresh,
    input wire logic [7:0] pfcReqValid,
    input wire logic [7:0] pfcTxEnable,
    input wire logic refreshTick,
    output logic [7:0] refreshSet
);

    localparam logic [15:0] TS_LAT_RESET = TS_ONE_STEP_CF ? `MFLPC_RST_TS_LAT_CF : `MFLPC_RST_TS_LAT_OTHER;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire hitRx = regAddr == `MFLPC_OFS_RX_LIMIT;
    wire hitTx = regAddr == `MFLPC_OFS_TX_LIMIT;
    wire hitTs = (regAddr == `MFLPC_OFS_TS_LATENCY) && TS_PRESENT;
    wire hitLegacy = (regAddr == `MFLPC_OFS_LEGACY) && PFC_PRESENT;
    wire prioRange = (regAddr >= `MFLPC_OFS_PRIO_FIRST) && (regAddr <= `MFLPC_OFS_PRIO_LAST)
        && (regAddr[1:0] == 2'h0);
    wire hitPrio = prioRange && PFC_PRESENT;
    wire [2:0] prioIndex = regAddr[4:2];

    wire wrRx = regWrEn && hitRx;
    wire wrTx = regWrEn && hitTx;
    wire wrTs = regWrEn && hitTs;
    wire wrLegacy = regWrEn && hitLegacy;

    // ****************************************************************
    // Frame length limits
    // ****************************************************************
    logic rxEnable_reg;
    logic rxEnable_next;
    logic [14:0] rxSize_reg;
    logic [14:0] rxSize_next;
    logic txEnable_reg;
    logic txEnable_next;
    logic [14:0] txSize_reg;
    logic [14:0] txSize_next;

    assign rxEnable_next = wrRx ? regWrData[`MFLPC_LIMIT_EN_BIT] : rxEnable_reg;
    assign rxSize_next = wrRx ? regWrData[`MFLPC_LIMIT_SIZE_MSB:0] : rxSize_reg;
    assign txEnable_next = wrTx ? regWrData[`MFLPC_LIMIT_EN_BIT] : txEnable_reg;
    assign txSize_next = wrTx ? regWrData[`MFLPC_LIMIT_SIZE_MSB:0] : txSize_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            rxEnable_reg <= `MFLPC_RST_LIMIT_EN;
            rxSize_reg <= `MFLPC_RST_LIMIT_SIZE;
            txEnable_reg <= `MFLPC_RST_LIMIT_EN;
            txSize_reg <= `MFLPC_RST_LIMIT_SIZE;
        end else begin
            rxEnable_reg <= rxEnable_next;
            rxSize_reg <= rxSize_next;
            txEnable_reg <= txEnable_next;
            txSize_reg <= txSize_next;
        end
    end

    assign limits = '{rxEnable: rxEnable_reg, rxSize: rxSize_reg, txEnable: txEnable_reg, txSize: txSize_reg};

    // ****************************************************************
    // Transmit timestamp latency
    // ****************************************************************
    logic tsCorr_reg;
    logic tsCorr_next;
    logic [15:0] tsLat_reg;
    logic [15:0] tsLat_next;

    assign tsCorr_next = wrTs ? regWrData[`MFLPC_TS_CORR_BIT] : tsCorr_reg;
    assign tsLat_next = wrTs ? regWrData[`MFLPC_TS_LAT_MSB:0] : tsLat_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            tsCorr_reg <= `MFLPC_RST_TS_CORR;
            tsLat_reg <= TS_LAT_RESET;
        end else begin
            tsCorr_reg <= tsCorr_next;
            tsLat_reg <= tsLat_next;
        end
    end

    // Without timestamping the adjustment is disabled and zero
    assign tsCfg = TS_PRESENT ? mflpc_pkg::mflpc_ts_s'{correctEnable: tsCorr_reg, latencyNs: tsLat_reg}
        : mflpc_pkg::mflpc_ts_s'{correctEnable: 1'b0, latencyNs: 16'h0000};

    // ****************************************************************
    // Legacy pause refresh
    // ****************************************************************
    logic [15:0] legacy_reg;
    logic [15:0] legacy_next;

    assign legacy_next = wrLegacy ? regWrData[31:`MFLPC_HALF_W] : legacy_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            legacy_reg <= `MFLPC_RST_REFRESH;
        end else begin
            legacy_reg <= legacy_next;
        end
    end

    assign legacyRefresh = PFC_PRESENT ? legacy_reg : 16'h0000;

    // ****************************************************************
    // Per-priority pause registers
    // ****************************************************************
    mflpc_pkg::mflpc_pause_arr_t prioValue;

    for (genvar p = 0; p < `MFLPC_PRIO_COUNT; p++) begin : gPrio
        wire prioWr = regWrEn && hitPrio && (prioIndex == 3'(p));
        mflpc_pause_slot uSlot (
            .clk(clk),
            .wrEn(prioWr),
            .wrData(regWrData),
            .value(prioValue[p])
        );
        assign pauseCfg[p] = PFC_PRESENT ? prioValue[p] : '0;
    end

    // ****************************************************************
    // Refresh set: every active priority joins each refresh
    // ****************************************************************
    logic [7:0] refreshSet_reg;
    logic [7:0] refreshSet_next;
    wire [7:0] activePrio = pfcReqValid & pfcTxEnable;

    assign refreshSet_next = (refreshTick && PFC_PRESENT) ? activePrio : 8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            refreshSet_reg <= 8'h00;
        end else begin
            refreshSet_reg <= refreshSet_next;
        end
    end

    assign refreshSet = refreshSet_reg;

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire [31:0] rdRx = {15'h0000, rxEnable_reg, 1'b0, rxSize_reg};
    wire [31:0] rdTx = {15'h0000, txEnable_reg, 1'b0, txSize_reg};
    wire [31:0] rdTs = {15'h0000, tsCorr_reg, tsLat_reg};
    wire [31:0] rdLegacy = {legacy_reg, 16'h0000};
    wire [31:0] rdPrio = prioValue[prioIndex];
    wire [31:0] rdMux = hitRx ? rdRx
        : hitTx ? rdTx
        : hitTs ? rdTs
        : hitLegacy ? rdLegacy
        : hitPrio ? rdPrio
        : 32'h00000000;

    logic [31:0] rdData_reg;
    logic [31:0] rdData_next;
    logic rdValid_reg;

    assign rdData_next = regRdEn ? rdMux : rdData_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            rdData_reg <= 32'h00000000;
            rdValid_reg <= 1'b0;
        end else begin
            rdData_reg <= rdData_next;
            rdValid_reg <= regRdEn;
        end
    end

    assign regRdData = rdData_reg;
    assign regRdValid = rdValid_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence sRxWrite;
        regWrEn && hitRx;
    endsequence

    sequence sRxReadBack;
        regRdEn && hitRx && !regWrEn;
    endsequence

    AST_RX_ENABLE: assert property (sRxWrite |=> limits.rxEnable == $past(regWrData[16]))
        else $error("rx limit enable not taken from bit 16");
    AST_RX_SIZE: assert property (sRxWrite ##1 sRxReadBack |=> regRdData[14:0] == $past(regWrData[14:0], 2))
        else $error("rx size not stored as written");
    AST_TX_ENABLE: assert property (regWrEn && hitTx |=> limits.txEnable == $past(regWrData[16]))
        else $error("tx limit enable not taken from bit 16");
    AST_TX_RESET: assert property (disable iff (1'b0) reset |=> limits.txSize == 15'h05EE && !limits.txEnable)
        else $error("tx size reset value wrong");
    AST_TS_RESET: assert property (disable iff (1'b0) reset |=> tsCfg.correctEnable == TS_PRESENT
        && tsCfg.latencyNs == (TS_PRESENT ? TS_LAT_RESET : 16'h0000))
        else $error("latency adjust reset value wrong");
    AST_TS_ABSENT: assert property (!TS_PRESENT && regRdEn && regAddr == `MFLPC_OFS_TS_LATENCY
        |=> regRdData == 32'h00000000)
        else $error("absent latency register read nonzero");
    AST_TS_WRITE: assert property (TS_PRESENT && regWrEn && hitTs
        |=> tsCfg.latencyNs == $past(regWrData[15:0]) && tsCfg.correctEnable == $past(regWrData[16]))
        else $error("latency adjust write not applied");
    AST_PRIO_WRITE: assert property (PFC_PRESENT && regWrEn && prioRange
        |=> pauseCfg[$past(prioIndex)] == $past(regWrData))
        else $error("priority pause write not applied");
    AST_PRIO_NO_RESET: assert property (disable iff (1'b0) reset && !regWrEn |=> $stable(pauseCfg))
        else $error("priority pause register changed on reset");
    AST_REFRESH_SET: assert property (PFC_PRESENT && refreshTick |=> refreshSet == $past(pfcReqValid & pfcTxEnable))
        else $error("refresh set does not match active priorities");
    AST_LEGACY_LOW: assert property (regRdEn && hitLegacy |=> regRdData[15:0] == 16'h0000)
        else $error("legacy refresh reserved half nonzero");
    AST_RESERVED_ZERO: assert property (regRdEn && (hitRx || hitTx || hitTs)
        |=> regRdData[31:17] == 15'h0000)
        else $error("reserved bits read nonzero");
    AST_READ_LATENCY: assert property (regRdEn |=> regRdValid ##1 !regRdValid || $past(regRdEn, 1))
        else $error("read answer not one cycle after request");

endmodule : mflpc_config

// ===== testbench/mflpc_config_tb_top.sv
module mflpc_config_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'h0;
    logic reset = 1'h1;
    logic regWrEn = 1'h0;
    logic regRdEn = 1'h0;
    logic [10:0] regAddr = 11'h000;
    logic [31:0] regWrData = 32'h00000000;
    logic [31:0] regRdData;
    logic regRdValid;
    mflpc_pkg::mflpc_limits_s limits;
    mflpc_pkg::mflpc_ts_s tsCfg;
    mflpc_pkg::mflpc_pause_arr_t pauseCfg;
    logic [15:0] legacyRefresh;
    logic [7:0] pfcReqValid = 8'h00;
    logic [7:0] pfcTxEnable = 8'h00;
    logic refreshTick = 1'h0;
    logic [7:0] refreshSet;
    int errors = 0;
    int compares = 0;
    logic [31:0] prioData [8];
    logic [31:0] leanRdData;
    mflpc_pkg::mflpc_ts_s leanTs;
    mflpc_pkg::mflpc_pause_arr_t leanPause;
    logic [15:0] leanLegacy;
    logic [7:0] leanRefresh;

    always #2.5 clk = ~clk;

    mflpc_config uut (
        .clk(clk),
        .reset(reset),
        .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regRdData(regRdData),
        .regRdValid(regRdValid),
        .limits(limits),
        .tsCfg(tsCfg),
        .pauseCfg(pauseCfg),
        .legacyRefresh(legacyRefresh),
        .pfcReqValid(pfcReqValid),
        .pfcTxEnable(pfcTxEnable),
        .refreshTick(refreshTick),
        .refreshSet(refreshSet)
    );

    // Build without timestamping and without priority flow control
    mflpc_config #(
        .TS_PRESENT(1'b0),
        .TS_ONE_STEP_CF(1'b0),
        .PFC_PRESENT(1'b0)
    ) uutLean (
        .clk(clk),
        .reset(reset),
        .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regRdData(leanRdData),
        .regRdValid(),
        .limits(),
        .tsCfg(leanTs),
        .pauseCfg(leanPause),
        .legacyRefresh(leanLegacy),
        .pfcReqValid(pfcReqValid),
        .pfcTxEnable(pfcTxEnable),
        .refreshTick(refreshTick),
        .refreshSet(leanRefresh)
    );

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [10:0] addr, input logic [31:0] data);
        @(negedge clk);
        regWrEn = 1'h1;
        regAddr = addr;
        regWrData = data;
        @(negedge clk);
        regWrEn = 1'h0;
    endtask : wr

    task automatic rd(input logic [10:0] addr, input logic [31:0] exp);
        @(negedge clk);
        regRdEn = 1'h1;
        regAddr = addr;
        @(negedge clk);
        regRdEn = 1'h0;
        chk({31'h0, regRdValid}, 32'h00000001, "read valid");
        chk(regRdData, exp, "read data");
    endtask : rd

    task automatic do_reset();
        @(negedge clk);
        reset = 1'h1;
        repeat (10) @(negedge clk);
        reset = 1'h0;
    endtask : do_reset

    task automatic tick(input logic [7:0] valid, input logic [7:0] en);
        @(negedge clk);
        refreshTick = 1'h1;
        pfcReqValid = valid;
        pfcTxEnable = en;
        @(negedge clk);
        refreshTick = 1'h0;
        chk({24'h0, refreshSet}, {24'h0, valid & en}, "active set");
        chk({24'h0, leanRefresh}, 32'h00000000, "absent refresh set");
        @(negedge clk);
        chk({24'h0, refreshSet}, 32'h00000000, "active set cleared");
    endtask : tick

    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (10) @(negedge clk);
        reset = 1'h0;
        rd(11'h414, 32'h000005EE);
        rd(11'h418, 32'h000005EE);
        rd(11'h420, 32'h00010080);
        chk({15'h0, tsCfg}, 32'h00010080, "latency outputs");
        rd(11'h4A0, 32'hFF000000);
        rd(11'h480, 32'hFF00FFFF);
        rd(11'h49C, 32'hFF00FFFF);
        $display("test reset_values done");

        wr(11'h414, 32'hFFFFFFFF);
        chk(limits, 32'hFFFF05EE, "rx limit outputs");
        rd(11'h414, 32'h00017FFF);
        wr(11'h414, 32'h00000610);
        rd(11'h414, 32'h00000610);
        wr(11'h418, 32'hFFFF0610);
        chk(limits, 32'h06108610, "tx limit outputs");
        rd(11'h418, 32'h00010610);
        @(negedge clk);
        regWrEn = 1'h1;
        regAddr = 11'h414;
        regWrData = 32'h00010700;
        @(negedge clk);
        regWrEn = 1'h0;
        regRdEn = 1'h1;
        @(negedge clk);
        regRdEn = 1'h0;
        chk(regRdData, 32'h00010700, "write then read");
        wr(11'h420, 32'hFFFE1234);
        chk({15'h0, tsCfg}, 32'h00001234, "latency outputs");
        rd(11'h420, 32'h00001234);
        wr(11'h420, 32'h00015678);
        rd(11'h420, 32'h00015678);
        chk(leanRdData, 32'h00000000, "absent latency read");
        chk({15'h0, leanTs}, 32'h00000000, "absent latency outputs");
        wr(11'h4A0, 32'hABCDFFFF);
        chk({16'h0, legacyRefresh}, 32'h0000ABCD, "legacy output");
        rd(11'h4A0, 32'hABCD0000);
        chk(leanRdData, 32'h00000000, "absent legacy read");
        chk({16'h0, leanLegacy}, 32'h00000000, "absent legacy output");
        $display("test field_access done");

        for (int p = 0; p < 8; p++) begin
            prioData[p] = {8'hC0, 8'(p), 8'h3C, 8'(p)};
            wr(11'h480 + 11'(4 * p), prioData[p]);
        end
        for (int p = 0; p < 8; p++) begin
            rd(11'h480 + 11'(4 * p), prioData[p]);
            chk(pauseCfg[p], prioData[p], "priority outputs");
            chk(leanRdData, 32'h00000000, "absent priority read");
            chk(leanPause[p], 32'h00000000, "absent priority outputs");
        end
        wr(11'h482, 32'h12345678);
        rd(11'h482, 32'h00000000);
        rd(11'h480, prioData[0]);
        rd(11'h4A4, 32'h00000000);
        wr(11'h47C, 32'h11111111);
        rd(11'h47C, 32'h00000000);
        $display("test priority_slots done");

        do_reset();
        rd(11'h414, 32'h000005EE);
        rd(11'h418, 32'h000005EE);
        rd(11'h420, 32'h00010080);
        rd(11'h4A0, 32'hFF000000);
        for (int p = 0; p < 8; p++) begin
            rd(11'h480 + 11'(4 * p), prioData[p]);
        end
        $display("test reset_keeps_priority done");

        tick(8'h0F, 8'h05);
        tick(8'hFF, 8'hFF);
        tick(8'hA5, 8'h3C);
        tick(8'hFF, 8'h00);
        $display("test refresh_set done");
        wrap_up();
    end

    initial begin
        #20000;
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : mflpc_config_tb_top
